// file: design/cmlf_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cmlf_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [PW:0]  wr_ptr_r;
  logic [PW:0]  rd_ptr_r;
  logic         full;
  logic         empty;

  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]) && (wr_ptr_r[PW] != rd_ptr_r[PW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_ptr_r[PW-1:0]];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_ptr_r <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: design/cmlf_line_fill.sv
// Cache miss handling: fill buffer, wrap-order line fetch, MRU tracking and copy-back
`timescale 1ns/1ps
`default_nettype none
module cmlf_line_fill
  import cmlf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Configuration
  input  wire logic              cache_on_bit,
  input  wire logic [1:0]        line_fill_select,
  input  wire logic              split_cfg,
  // Processor fetch request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_instr,
  input  wire logic              req_cacheable,
  input  wire logic              tag_hit,
  // Processor response
  output logic                   rsp_valid,
  input  wire logic              rsp_ready,
  output logic [DATA_W-1:0]      rsp_data,
  // External bus fetch port
  output logic                   bus_req_valid,
  input  wire logic              bus_req_ready,
  output logic [ADDR_W-1:0]      bus_req_addr,
  output logic [1:0]             bus_req_size,
  input  wire logic              bus_rd_valid,
  output logic                   bus_rd_ready,
  input  wire logic [DATA_W-1:0] bus_rd_data,
  // Cache array line write
  output logic                   arr_wr_valid,
  input  wire logic              arr_wr_ready,
  output logic [TAG_W-1:0]       arr_wr_line,
  output logic [LINE_W-1:0]      arr_wr_data
);
  cmlf_state_type        state_r;
  logic [ADDR_W-1:0]     cur_addr_r;
  logic                  cur_cached_r;
  logic [1:0]            cur_size_r;
  logic [CNT_W-1:0]      issue_cnt_r;
  logic [CNT_W-1:0]      beat_cnt_r;
  logic [DATA_W-1:0]     lfb_word_r [LINE_WORDS];
  logic [LINE_WORDS-1:0] lfb_valid_r;
  logic [TAG_W-1:0]      lfb_line_r;
  logic                  mru_r;
  logic [DATA_W-1:0]     hit_data_r;
  logic                  fifo_ov;
  logic                  drain_rdy;
  logic [DATA_W-1:0]     fifo_dout;
  logic                  accept;
  logic                  cached_ref;
  logic                  lfb_hit;
  logic                  miss;
  logic                  idx_match;
  logic                  lfb_full;
  logic [1:0]            req_wsel;
  logic [1:0]            new_size;
  logic [CNT_W-1:0]      nbeats;

  // Longword slot of beat n in a fetch that starts at the critical slot
  function automatic logic [1:0] wrap_sel(input logic [1:0] crit, input logic [CNT_W-1:0] n);
    wrap_sel = crit + n[1:0];
  endfunction

  // Array index comparison, narrower in the split arrangement
  function automatic logic same_index(input logic [ADDR_W-1:0] a, input logic [TAG_W-1:0] line,
                                      input logic split);
    logic [IDX_W-1:0] ia;
    logic [IDX_W-1:0] ib;
    ia = a[IDX_HI:LINE_LO];
    ib = line[IDX_W-1:0];
    if (split) begin
      ia[IDX_W-1] = 1'b0;
      ib[IDX_W-1] = 1'b0;
    end
    same_index = (ia == ib);
  endfunction

  assign req_wsel   = req_addr[WSEL_HI:WSEL_LO];
  assign accept     = req_valid && req_ready;
  assign cached_ref = cache_on_bit && req_cacheable;
  assign lfb_hit    = (req_addr[ADDR_W-1:LINE_LO] == lfb_line_r) && lfb_valid_r[req_wsel];
  assign miss       = cached_ref && !tag_hit && !lfb_hit;
  assign idx_match  = same_index(req_addr, lfb_line_r, split_cfg);
  assign lfb_full   = &lfb_valid_r;
  assign nbeats     = (cur_size_r == SZ_LINE) ? BEATS_LINE : BEATS_ONE;

  // Fetch size for a new request
  always_comb begin
    new_size = SZ_LONG;
    if (miss) begin
      if (!req_instr) begin
        new_size = SZ_LINE;
      end else if (line_fill_select[LFS_LINE_BIT]) begin
        new_size = SZ_LINE;
      end else if (line_fill_select == LFS_LAST_LONG) begin
        new_size = (req_wsel == WSEL_LAST) ? SZ_LONG : SZ_LINE;
      end else begin
        new_size = req_wsel[1] ? SZ_LONG : SZ_LINE;
      end
    end else if (req_instr && req_addr[WORD_BIT]) begin
      new_size = SZ_WORD;
    end
  end

  assign req_ready     = (state_r == ST_IDLE);
  assign bus_req_valid = (state_r == ST_BUSY) && (issue_cnt_r < nbeats);
  assign bus_req_size  = (cur_size_r == SZ_LINE) ? SZ_LONG : cur_size_r;
  assign bus_req_addr  = (cur_size_r == SZ_LINE)
                       ? {cur_addr_r[ADDR_W-1:LINE_LO],
                          wrap_sel(cur_addr_r[WSEL_HI:WSEL_LO], issue_cnt_r), 2'h0}
                       : cur_addr_r;
  // Critical word waits on the processor; the FIFO holds the stalled beats, at most 4 of its 16 entries, so it never backs up into the bus
  assign drain_rdy     = (state_r == ST_BUSY) && ((beat_cnt_r != '0) || rsp_ready);
  assign rsp_valid     = (state_r == ST_HIT)
                       || ((state_r == ST_BUSY) && (beat_cnt_r == '0) && fifo_ov);
  assign rsp_data      = (state_r == ST_HIT) ? hit_data_r : fifo_dout;
  assign arr_wr_valid  = (state_r == ST_COPY);
  assign arr_wr_line   = lfb_line_r;
  assign arr_wr_data   = {lfb_word_r[3], lfb_word_r[2], lfb_word_r[1], lfb_word_r[0]};

  cmlf_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (bus_rd_valid),
    .in_ready  (bus_rd_ready),
    .in_data   (bus_rd_data),
    .out_valid (fifo_ov),
    .out_ready (drain_rdy),
    .out_data  (fifo_dout)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept && miss) begin
            state_r <= (lfb_full && mru_r) ? ST_COPY : ST_BUSY;
          end else if (accept && cached_ref && !tag_hit) begin
            state_r <= ST_HIT;
          end else if (accept && !cached_ref) begin
            state_r <= ST_BUSY;
          end
        end
        ST_COPY: begin
          if (arr_wr_ready) begin
            state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (fifo_ov && drain_rdy && (beat_cnt_r == nbeats - 1'b1)) begin
            state_r <= ST_IDLE;
          end
        end
        ST_HIT: begin
          if (rsp_ready) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_addr_r   <= '0;
      cur_cached_r <= 1'b0;
      cur_size_r   <= SZ_LONG;
    end else if (accept) begin
      cur_addr_r   <= req_addr;
      cur_cached_r <= miss;
      cur_size_r   <= new_size;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      issue_cnt_r <= '0;
    end else if (accept) begin
      issue_cnt_r <= '0;
    end else if (bus_req_valid && bus_req_ready) begin
      issue_cnt_r <= issue_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      beat_cnt_r <= '0;
    end else if (accept) begin
      beat_cnt_r <= '0;
    end else if (fifo_ov && drain_rdy) begin
      beat_cnt_r <= beat_cnt_r + 1'b1;
    end
  end

  // Buffer words land in their wrapped slot as they drain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LINE_WORDS; i++) begin
        lfb_word_r[i] <= '0;
      end
    end else if (fifo_ov && drain_rdy && cur_cached_r) begin
      lfb_word_r[wrap_sel(cur_addr_r[WSEL_HI:WSEL_LO], beat_cnt_r)] <= fifo_dout;
    end
  end

  // Valid flags are cleared when a cached fetch starts in ST_BUSY, after the copy-out of the old line if there is one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lfb_valid_r <= '0;
      lfb_line_r  <= '0;
    end else if (state_r == ST_BUSY && cur_cached_r && beat_cnt_r == '0 && issue_cnt_r == '0) begin
      lfb_valid_r <= '0;
      lfb_line_r  <= cur_addr_r[ADDR_W-1:LINE_LO];
      if (fifo_ov && drain_rdy) begin
        lfb_valid_r[cur_addr_r[WSEL_HI:WSEL_LO]] <= 1'b1;
      end
    end else if (fifo_ov && drain_rdy && cur_cached_r) begin
      lfb_valid_r[wrap_sel(cur_addr_r[WSEL_HI:WSEL_LO], beat_cnt_r)] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mru_r <= 1'b0;
    end else if (accept && miss) begin
      mru_r <= 1'b1;
    end else if (accept && cached_ref && tag_hit && idx_match) begin
      mru_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hit_data_r <= '0;
    end else if (accept && cached_ref && !tag_hit && lfb_hit) begin
      hit_data_r <= lfb_word_r[req_wsel];
    end
  end

  // A copy-back may stall on the array for any time, so only copy-free misses are timed here
  property p_miss_fetch;
    @(posedge clk_sys) disable iff (rst)
      (accept && miss && !(lfb_full && mru_r)) |=> bus_req_valid;
  endproperty
  a_miss_fetch: assert property (p_miss_fetch) else $error("Miss fetch not started");

  property p_data_line;
    @(posedge clk_sys) disable iff (rst)
      (accept && miss && !req_instr) |=> (cur_size_r == SZ_LINE);
  endproperty
  a_data_line: assert property (p_data_line) else $error("Data miss not a line fetch");

  property p_instr_last;
    @(posedge clk_sys) disable iff (rst)
      (accept && miss && req_instr && line_fill_select == LFS_LAST_LONG && req_wsel == WSEL_LAST)
      |=> (cur_size_r == SZ_LONG);
  endproperty
  a_instr_last: assert property (p_instr_last) else $error("Instruction miss size wrong");

  property p_wrap;
    @(posedge clk_sys) disable iff (rst)
      (bus_req_valid && cur_size_r == SZ_LINE && issue_cnt_r == '0)
      |-> (bus_req_addr[WSEL_HI:WSEL_LO] == cur_addr_r[WSEL_HI:WSEL_LO]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Critical longword not first");

  property p_mru_set;
    @(posedge clk_sys) disable iff (rst) (accept && miss) |=> mru_r ##1 mru_r;
  endproperty
  a_mru_set: assert property (p_mru_set) else $error("Indicator not set on miss");

  property p_mru_clr;
    @(posedge clk_sys) disable iff (rst) (accept && cached_ref && tag_hit && idx_match) |=> !mru_r;
  endproperty
  a_mru_clr: assert property (p_mru_clr) else $error("Indicator not cleared on hit");

  property p_copy;
    @(posedge clk_sys) disable iff (rst) arr_wr_valid |-> (mru_r && lfb_full);
  endproperty
  a_copy: assert property (p_copy) else $error("Copy of partial or stale buffer");

  property p_odd_word;
    @(posedge clk_sys) disable iff (rst)
      (accept && !cached_ref && req_instr && req_addr[WORD_BIT])
      |=> ##[0:2] (bus_req_size == SZ_WORD);
  endproperty
  a_odd_word: assert property (p_odd_word) else $error("Odd word fetch not word sized");
endmodule
`default_nettype wire

// file: design/cmlf_pkg.sv
// Constants, types and fetch-size encodings for the cache miss line-fill block
package cmlf_pkg;
  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 32;
  localparam int LINE_WORDS   = 4;
  localparam int LINE_W       = DATA_W * LINE_WORDS;
  localparam int FIFO_DEPTH   = 16;
  localparam int WORD_BIT     = 1;
  localparam int WSEL_LO      = 2;
  localparam int WSEL_HI      = 3;
  localparam int LINE_LO      = 4;
  localparam int IDX_HI       = 10;
  localparam int IDX_HI_SPLIT = 9;
  localparam int IDX_W        = IDX_HI - LINE_LO + 1;
  localparam int TAG_W        = ADDR_W - LINE_LO;
  localparam int CNT_W        = 3;
  // Fetch sizes; SZ_WORD and SZ_LONG are driven on the bus fetch port, SZ_LINE is sent there as SZ_LONG
  localparam logic [1:0] SZ_WORD = 2'h0;
  localparam logic [1:0] SZ_LONG = 2'h1;
  localparam logic [1:0] SZ_LINE = 2'h2;
  // Line-fill select settings
  localparam logic [1:0] LFS_LAST_LONG = 2'h0;
  localparam logic [1:0] LFS_HALF_LONG = 2'h1;
  localparam int         LFS_LINE_BIT  = 1;
  localparam logic [1:0] WSEL_LAST     = 2'h3;
  localparam logic [CNT_W-1:0] BEATS_LINE = 3'h4;
  localparam logic [CNT_W-1:0] BEATS_ONE  = 3'h1;
  typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_BUSY, ST_HIT} cmlf_state_type;
endpackage

// file: verif/cmlf_bus_model.sv
// Bus fetch port responder: random request stalls, in-order data after random latency
`timescale 1ns/1ps
`default_nettype none
module cmlf_bus_model
  import cmlf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Request side
  input  wire logic              bus_req_valid,
  output logic                   bus_req_ready,
  input  wire logic [ADDR_W-1:0] bus_req_addr,
  // Read data side
  output logic                   bus_rd_valid,
  input  wire logic              bus_rd_ready,
  output logic [DATA_W-1:0]      bus_rd_data
);
  logic [ADDR_W-1:0] pend_q[$];
  logic              rd_done;
  integer            seed = 33;

  // Handshakes are taken at the rising edge; the outputs only move at the falling edge
  always @(posedge clk_sys) begin
    rd_done = 1'b0;
    if (rst) begin
      pend_q.delete();
    end else begin
      if (bus_req_valid && bus_req_ready)
        pend_q.push_back(bus_req_addr);
      if (bus_rd_valid && bus_rd_ready) begin
        void'(pend_q.pop_front());
        rd_done = 1'b1;
      end
    end
  end

  // Idle data lines toggle so a stale word is never mistaken for a fresh one
  always @(negedge clk_sys) begin
    bus_req_ready <= |($random(seed) & 3);
    if (rst) begin
      bus_rd_valid <= 1'b0;
      bus_rd_data <= 32'h0;
    end else if (!bus_rd_valid || rd_done) begin
      if (pend_q.size() > 0 && 1'($random(seed))) begin
        bus_rd_valid <= 1'b1;
        bus_rd_data <= {pend_q[0][31:2], 2'h0} ^ 32'hC3A5_0000;
      end else begin
        bus_rd_valid <= 1'b0;
        bus_rd_data <= ~bus_rd_data;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/cmlf_line_fill_tb.sv
// Self-checking bench: queue-based line-fill model compared with the design
`timescale 1ns/1ps
`default_nettype none
module cmlf_line_fill_tb
  import cmlf_pkg::*;
;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         cache_on_bit, split_cfg, req_valid, req_ready, req_instr, req_cacheable;
  logic         tag_hit, rsp_valid, rsp_ready, bus_req_valid, bus_req_ready;
  logic         bus_rd_valid, bus_rd_ready, arr_wr_valid, arr_wr_ready, b_mru;
  logic [1:0]   line_fill_select, bus_req_size;
  logic [3:0]   b_vld;
  logic [31:0]  req_addr, rsp_data, bus_req_addr, bus_rd_data, r;
  logic [31:0]  b_dat [4];
  logic [27:0]  arr_wr_line, b_line;
  logic [127:0] arr_wr_data;
  logic [33:0]  eb_q[$];
  logic [31:0]  er_q[$];
  logic [155:0] ea_q[$];
  integer       seed = 33, num_errors = 0, samples_checked = 0, cyc = 0;

  cmlf_line_fill i_cmlf_line_fill (.clk_sys, .rst, .cache_on_bit, .line_fill_select,
    .split_cfg, .req_valid, .req_ready, .req_addr, .req_instr, .req_cacheable, .tag_hit,
    .rsp_valid, .rsp_ready, .rsp_data, .bus_req_valid, .bus_req_ready, .bus_req_addr,
    .bus_req_size, .bus_rd_valid, .bus_rd_ready, .bus_rd_data, .arr_wr_valid,
    .arr_wr_ready, .arr_wr_line, .arr_wr_data);
  cmlf_bus_model i_cmlf_bus_model (.clk_sys, .rst, .bus_req_valid, .bus_req_ready,
    .bus_req_addr, .bus_rd_valid, .bus_rd_ready, .bus_rd_data);

  initial forever #10 clk_sys = ~clk_sys;

  task automatic check(input logic [155:0] seen, input logic [155:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic results;
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Every design result is compared as it is handed over
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results;
    end
    if (!rst && bus_req_valid && bus_req_ready)
      check({bus_req_size, bus_req_addr}, eb_q.size() ? eb_q.pop_front() : 'x, "bus req");
    if (!rst && rsp_valid && rsp_ready)
      check(rsp_data, er_q.size() ? er_q.pop_front() : 'x, "response");
    if (!rst && arr_wr_valid && arr_wr_ready)
      check({arr_wr_line, arr_wr_data}, ea_q.size() ? ea_q.pop_front() : 'x, "copy");
  end

  // Random stalls on the processor side back up the FIFO; array stalls hold up the copy-back
  always @(negedge clk_sys) begin
    rsp_ready = |($random(seed) & 3);
    arr_wr_ready = 1'($random(seed));
  end

  task automatic access(input logic [31:0] a, input logic ins, cab, th);
    logic [1:0] s;
    logic [1:0] t;
    logic       ln;
    s = a[3:2];
    ln = !ins || line_fill_select[1] || s < 2'h2 || (!line_fill_select[0] && s != 2'h3);
    if (!cab || !cache_on_bit) begin
      eb_q.push_back({(ins && a[1]) ? SZ_WORD : SZ_LONG, a});
      er_q.push_back({a[31:2], 2'h0} ^ 32'hC3A5_0000);
    end else if (th) begin
      if (split_cfg ? a[9:4] == b_line[5:0] : a[10:4] == b_line[6:0])
        b_mru = 1'b0;
    end else if (a[31:4] == b_line && b_vld[s])
      er_q.push_back(b_dat[s]);
    else begin
      if (&b_vld && b_mru)
        ea_q.push_back({b_line, b_dat[3], b_dat[2], b_dat[1], b_dat[0]});
      b_mru = 1'b1;
      b_line = a[31:4];
      b_vld = ln ? 4'hF : 4'h1 << s;
      for (int k = 0; k < (ln ? 4 : 1); k++) begin
        t = s + k[1:0];
        b_dat[t] = {a[31:4], t, 2'h0} ^ 32'hC3A5_0000;
        eb_q.push_back({SZ_LONG, ln ? {a[31:4], t, 2'h0} : a});
      end
      er_q.push_back(b_dat[s]);
    end
    @(negedge clk_sys);
    {req_valid, req_addr, req_instr, req_cacheable, tag_hit} = {1'b1, a, ins, cab, th};
    do @(posedge clk_sys); while (!req_ready);
    @(negedge clk_sys);
    {req_valid, tag_hit} = 2'h0;
    do @(posedge clk_sys); while (!req_ready);
  endtask

  initial begin
    {cache_on_bit, split_cfg, req_valid, req_instr, req_cacheable, tag_hit} = 6'h0;
    {line_fill_select, req_addr} = '0;
    {b_line, b_vld, b_mru} = '0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    // Outputs while reset is still held: idle handshakes, empty FIFO, cleared buffer
    check({req_ready, rsp_valid, bus_req_valid, bus_rd_ready, arr_wr_valid}, 5'h12, "idle");
    check({bus_req_size, bus_req_addr}, {SZ_LONG, 32'h0}, "reset fetch port");
    check({arr_wr_line, arr_wr_data}, 156'h0, "reset buffer");
    rst = 1'b0;
    cache_on_bit = 1'b1;
    for (int c = 0; c < 4; c++) begin
      line_fill_select = c[1:0];
      for (int w = 0; w < 4; w++)
        access(32'h1000 + c * 64 + w * 20, 1'b1, 1'b1, 1'b0);
    end
    line_fill_select = 2'h0;
    for (int w = 0; w < 4; w++)
      access(32'h2000 + w * 20, 1'b0, 1'b1, 1'b0);
    access(32'h2034, 1'b0, 1'b1, 1'b0);
    access(32'h2430, 1'b0, 1'b1, 1'b1);
    split_cfg = 1'b1;
    access(32'h2430, 1'b0, 1'b1, 1'b1);
    access(32'h3000, 1'b0, 1'b1, 1'b0);
    access(32'h4002, 1'b1, 1'b0, 1'b0);
    access(32'h4004, 1'b1, 1'b0, 1'b0);
    cache_on_bit = 1'b0;
    access(32'h4008, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_sys);
      r = $random(seed);
      {cache_on_bit, line_fill_select, split_cfg} = {r[2:0] != 3'h0, r[4:3], r[5]};
      access(r & 32'h0000_0C3E, r[6], r[7] | r[8], r[9] & r[10] & r[7] & cache_on_bit);
    end
    repeat (10) @(posedge clk_sys);
    check(eb_q.size() + er_q.size() + ea_q.size(), 0, "results outstanding");
    results;
  end
endmodule
`default_nettype wire
